/* File: shared/ptp_trig_pkg.sv */
// constants, register map and types for the ptp trigger output unit
package ptp_trig_pkg;
  // unit counts
  localparam int NUM_TRIG = 4;
  localparam int NUM_CAP = 2;
  // register offsets
  localparam logic [11:0] OFF_INDEX = 12'h0524;
  localparam logic [11:0] OFF_CTRL = 12'h052C;
  localparam logic [11:0] OFF_TGT_NS = 12'h0530;
  localparam logic [11:0] OFF_TGT_SEC = 12'h0534;
  localparam logic [11:0] OFF_CTL1 = 12'h0538;
  localparam logic [11:0] OFF_STATUS = 12'h0540;
  // index register fields
  localparam int IDX_CAP_BIT = 8;
  localparam int IDX_TRIG_LSB = 0;
  // control and status register fields
  localparam int CAP_RST_BIT = 0;
  localparam int CAP_EN_BIT = 1;
  localparam int TRIG_RST_BIT = 2;
  localparam int TRIG_EN_BIT = 3;
  localparam int TRIG_ACT_BIT = 4;
  localparam int CAP_INT_BIT = 5;
  // control one fields
  localparam int CHAIN_BIT = 31;
  localparam int TAIL_BIT = 30;
  localparam int UPSEL_LSB = 26;
  localparam int NOW_BIT = 25;
  localparam int NOTIFY_BIT = 24;
  localparam int EDGE_BIT = 23;
  localparam int PAT_LSB = 20;
  // status register fields
  localparam int DONE_LSB = 0;
  localparam int ERR_LSB = 4;
  // nanosecond field width
  localparam int NS_W = 30;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // pulse width of pulse-type patterns
  localparam int CLK_NS = 8;
  localparam int PULSE_NS = 80;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  // pattern codes
  localparam logic [2:0] PAT_NEG_EDGE = 3'h0;
  localparam logic [2:0] PAT_POS_EDGE = 3'h1;
  localparam logic [2:0] PAT_POS_PULSE = 3'h3;
  localparam logic [2:0] PAT_POS_PER = 3'h5;
  localparam logic [2:0] PAT_RESERVED = 3'h7;
  // per-unit control one contents
  typedef struct packed {
    logic chain;
    logic tail;
    logic [1:0] upSel;
    logic now;
    logic notify;
    logic negEdge;
    logic [2:0] pattern;
  } ctl_t;
  localparam ctl_t CTL_RST = '0;
  // unit sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_PULSE = 3'b100
  } state_t;
endpackage

/* File: core/ptp_trigger_output_unit.sv */
// trigger output units with indexed register access and cascade chaining
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - capture soft reset bit restores capture unit
// - capture soft reset hits indexed capture unit
// - target and control steered by trigger index
// - nanosecond target thirty bits, upper bits zero
// - seconds target full thirty-two bits
// - control bit 31 enables chain mode
// - control bit 30 marks chain tail
// - no tail means chain loops forever
// - bits 27:26 pick upstream done unit
// - bit 25 fires late targets at once
// - bit 24 gates done and fault flags
// - bit 23 picks output change edge
// - enable clears itself after output generated
// - fire soft reset restores indexed unit
// - bits 22:20 select output waveform
module ptp_trigger_output_unit
  import ptp_trig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  input wire logic [31:0] sysSec,
  input wire logic [NS_W-1:0] sysNs,
  output logic [NUM_TRIG-1:0] trigOut,
  output logic [NUM_TRIG-1:0] fireCompleteFlag,
  output logic [NUM_TRIG-1:0] fireFaultFlag,
  output logic [NUM_CAP-1:0] capEnable
);

  // target reached test, seconds and nanoseconds as one number
  function automatic logic reached(input logic [31:0] s, input logic [NS_W-1:0] n,
                                   input logic [31:0] ts, input logic [NS_W-1:0] tn);
    reached = {s, n} >= {ts, tn};
  endfunction

  // idle level of a pattern: low for the positive-going ones
  function automatic logic idleLevel(input logic [2:0] p);
    idleLevel = !(p == PAT_POS_EDGE || p == PAT_POS_PULSE || p == PAT_POS_PER);
  endfunction

  // register state
  logic [1:0] trigIdx_r; // trigger unit pointer
  logic capIdx_r; // capture unit pointer
  logic [NS_W-1:0] tgtNs_r [NUM_TRIG]; // nanosecond targets
  logic [31:0] tgtSec_r [NUM_TRIG]; // second targets
  ctl_t ctl_r [NUM_TRIG]; // control one per unit
  state_t state_r [NUM_TRIG]; // sequencer per unit
  logic [7:0] pulseCnt_r [NUM_TRIG]; // pulse length counter
  logic [NUM_TRIG-1:0] lvl_r; // raw output level
  logic [NUM_TRIG-1:0] lvlDly_r; // level held one cycle longer
  logic [NUM_TRIG-1:0] doneEvt_r; // one-cycle done pulse per unit
  logic [NUM_CAP-1:0] capIntEn_r; // capture interrupt enables
  logic [NUM_TRIG-1:0] trigOut_r;
  logic [NUM_TRIG-1:0] fireComplete_r;
  logic [NUM_TRIG-1:0] fireFault_r;
  logic [NUM_CAP-1:0] capEnable_r;
  logic [31:0] rdData_r;

  // address decode
  wire wrIndex = regWr && regAddr == OFF_INDEX;
  wire wrCtrl = regWr && regAddr == OFF_CTRL;
  wire wrNs = regWr && regAddr == OFF_TGT_NS;
  wire wrSec = regWr && regAddr == OFF_TGT_SEC;
  wire wrCtl1 = regWr && regAddr == OFF_CTL1;
  wire wrStat = regWr && regAddr == OFF_STATUS;
  wire fireRst = wrCtrl && regWrData[TRIG_RST_BIT];
  wire capRst = wrCtrl && regWrData[CAP_RST_BIT];
  wire [7:0] pulseLoad = 8'(PULSE_CYC);

  // per-unit decode of events
  logic [NUM_TRIG-1:0] sel, hit, swArm, chainArm, arm, late, fire, pulseEnd;
  always_comb begin
    for (int i = 0; i < NUM_TRIG; i++) begin
      sel[i] = trigIdx_r == 2'(i);
      hit[i] = reached(sysSec, sysNs, tgtSec_r[i], tgtNs_r[i]);
      swArm[i] = wrCtrl && sel[i] && regWrData[TRIG_EN_BIT] && !regWrData[TRIG_RST_BIT];
      // a done from a tail ends the chain; with no tail the loop never ends
      chainArm[i] = ctl_r[i].chain && doneEvt_r[ctl_r[i].upSel]
                    && !ctl_r[ctl_r[i].upSel].tail;
      arm[i] = state_r[i] == ST_IDLE && (swArm[i] || chainArm[i]);
      // a target already past is a fault unless fire-now is set
      late[i] = hit[i] && !ctl_r[i].now;
      fire[i] = state_r[i] == ST_ARMED && hit[i];
      pulseEnd[i] = state_r[i] == ST_PULSE && pulseCnt_r[i] == 8'h01;
    end
  end

  // read multiplexer
  wire [NUM_TRIG-1:0] active;
  wire [31:0] ctl1Word = {ctl_r[trigIdx_r].chain, ctl_r[trigIdx_r].tail, 2'h0,
                          ctl_r[trigIdx_r].upSel, ctl_r[trigIdx_r].now,
                          ctl_r[trigIdx_r].notify, ctl_r[trigIdx_r].negEdge,
                          ctl_r[trigIdx_r].pattern, 20'h0_0000};
  wire [31:0] ctrlWord = {26'h0, capIntEn_r[capIdx_r], active[trigIdx_r],
                          state_r[trigIdx_r] == ST_ARMED, 1'b0, capEnable_r[capIdx_r], 1'b0};
  wire [31:0] rdMux = regAddr == OFF_INDEX ? {23'h0, capIdx_r, 6'h0, trigIdx_r} :
                      regAddr == OFF_CTRL ? ctrlWord :
                      regAddr == OFF_TGT_NS ? {2'h0, tgtNs_r[trigIdx_r]} :
                      regAddr == OFF_TGT_SEC ? tgtSec_r[trigIdx_r] :
                      regAddr == OFF_CTL1 ? ctl1Word :
                      regAddr == OFF_STATUS ? {24'h0, fireFault_r, fireComplete_r} :
                      RST_WORD;
  genvar g;
  for (g = 0; g < NUM_TRIG; g++) begin : gAct
    assign active[g] = state_r[g] != ST_IDLE;
  end

  // index pointers and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      trigIdx_r <= 2'h0;
      capIdx_r <= 1'b0;
      rdData_r <= RST_WORD;
    end else begin
      if (wrIndex) begin
        trigIdx_r <= regWrData[IDX_TRIG_LSB +: 2];
        capIdx_r <= regWrData[IDX_CAP_BIT];
      end
      if (regRd) begin
        rdData_r <= rdMux;
      end
    end
  end

  // capture units: only enable bits and their soft reset live here
  always_ff @(posedge clk) begin
    if (rst) begin
      capEnable_r <= '0;
      capIntEn_r <= '0;
    end else if (capRst) begin
      capEnable_r[capIdx_r] <= 1'b0;
      capIntEn_r[capIdx_r] <= 1'b0;
    end else if (wrCtrl) begin
      capEnable_r[capIdx_r] <= regWrData[CAP_EN_BIT];
      capIntEn_r[capIdx_r] <= regWrData[CAP_INT_BIT];
    end
  end

  // trigger unit configuration, sequencing and output
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        tgtNs_r[i] <= '0;
        tgtSec_r[i] <= '0;
        ctl_r[i] <= CTL_RST;
        state_r[i] <= ST_IDLE;
        pulseCnt_r[i] <= 8'h00;
      end
      lvl_r <= '1;
      lvlDly_r <= '1;
      trigOut_r <= '1;
      doneEvt_r <= '0;
      fireComplete_r <= '0;
      fireFault_r <= '0;
    end else begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        doneEvt_r[i] <= 1'b0;
        // done/fault: set wins over a write-one clear
        if (wrStat && regWrData[DONE_LSB + i]) begin
          fireComplete_r[i] <= 1'b0;
        end
        if (wrStat && regWrData[ERR_LSB + i]) begin
          fireFault_r[i] <= 1'b0;
        end
        if (fireRst && sel[i]) begin
          // back to inactive with default settings; stops a looping chain
          tgtNs_r[i] <= '0;
          tgtSec_r[i] <= '0;
          ctl_r[i] <= CTL_RST;
          state_r[i] <= ST_IDLE;
          pulseCnt_r[i] <= 8'h00;
          lvl_r[i] <= idleLevel(PAT_NEG_EDGE);
          fireComplete_r[i] <= 1'b0;
          fireFault_r[i] <= 1'b0;
        end else begin
          if (wrNs && sel[i]) begin
            tgtNs_r[i] <= regWrData[NS_W-1:0];
          end
          if (wrSec && sel[i]) begin
            tgtSec_r[i] <= regWrData;
          end
          if (wrCtl1 && sel[i] && state_r[i] == ST_IDLE) begin
            // reserved bits 29:28 are dropped so the fields land in their own places
            ctl_r[i] <= ctl_t'({regWrData[31:30], regWrData[27:20]});
            lvl_r[i] <= idleLevel(regWrData[PAT_LSB +: 3]);
          end
          unique case (state_r[i])
            ST_IDLE: begin
              if (arm[i] && late[i]) begin
                // written only when reported, so a clear of an unreported unit stands
                if (ctl_r[i].notify) begin
                  fireFault_r[i] <= 1'b1;
                end
              end else if (arm[i]) begin
                state_r[i] <= ST_ARMED;
              end
            end
            ST_ARMED: begin
              if (wrCtrl && sel[i] && !regWrData[TRIG_EN_BIT]) begin
                state_r[i] <= ST_IDLE; // software disable
              end else if (fire[i] && ctl_r[i].pattern == PAT_RESERVED) begin
                state_r[i] <= ST_IDLE; // reserved code drives nothing
                if (ctl_r[i].notify) begin
                  fireFault_r[i] <= 1'b1;
                end
              end else if (fire[i] && ctl_r[i].pattern <= PAT_POS_EDGE) begin
                // edges: leave the idle level and stay there
                lvl_r[i] <= !idleLevel(ctl_r[i].pattern);
                state_r[i] <= ST_IDLE;
                doneEvt_r[i] <= 1'b1;
                // set after the clear above, so the event wins a same-cycle clear
                if (ctl_r[i].notify) begin
                  fireComplete_r[i] <= 1'b1;
                end
              end else if (fire[i]) begin
                lvl_r[i] <= !idleLevel(ctl_r[i].pattern);
                pulseCnt_r[i] <= pulseLoad;
                state_r[i] <= ST_PULSE;
              end
            end
            ST_PULSE: begin
              pulseCnt_r[i] <= pulseCnt_r[i] - 8'h01;
              if (pulseEnd[i]) begin
                lvl_r[i] <= idleLevel(ctl_r[i].pattern);
                state_r[i] <= ST_IDLE;
                doneEvt_r[i] <= 1'b1;
                if (ctl_r[i].notify) begin
                  fireComplete_r[i] <= 1'b1;
                end
              end
            end
          endcase
        end
        // one clock only: the late edge is a half-step stand-in, one cycle later
        lvlDly_r[i] <= lvl_r[i];
        trigOut_r[i] <= ctl_r[i].negEdge ? lvlDly_r[i] : lvl_r[i];
      end
    end
  end

  assign regRdData = rdData_r;
  assign trigOut = trigOut_r;
  assign fireCompleteFlag = fireComplete_r;
  assign fireFaultFlag = fireFault_r;
  assign capEnable = capEnable_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  cap_reset_a: assert property (capRst |=> !capEnable_r[$past(capIdx_r)])
    else $error("capture soft reset ignored");
  cap_index_a: assert property (capRst && !wrIndex |=>
      capEnable_r[!capIdx_r] == $past(capEnable_r[!capIdx_r]))
    else $error("capture soft reset hit other unit");
  ns_steer_a: assert property (wrNs && !fireRst |=>
      tgtNs_r[$past(trigIdx_r)] == $past(regWrData[NS_W-1:0]))
    else $error("nanosecond write misdirected");
  ns_upper_a: assert property (regRd && regAddr == OFF_TGT_NS |=> rdData_r[31:30] == 2'h0)
    else $error("reserved nanosecond bits nonzero");
  sec_store_a: assert property (wrSec |=> tgtSec_r[$past(trigIdx_r)] == $past(regWrData))
    else $error("seconds write lost");
  late_fault_a: assert property (arm[0] && late[0] && ctl_r[0].notify |=>
      fireFault_r[0] && state_r[0] == ST_IDLE)
    else $error("late target not faulted");
  notify_gate_a: assert property (!ctl_r[0].notify && !fireComplete_r[0] |=> !fireComplete_r[0])
    else $error("done reported without notify");
  // unit 0 is the one that runs with the late edge selected
  edge_delay_a: assert property (ctl_r[0].negEdge && $past(ctl_r[0].negEdge) |=>
      trigOut_r[0] == $past(lvl_r[0], 2))
    else $error("late-edge output timing wrong");
  // unit 1 finishes edge patterns as a chain member
  self_clear_a: assert property (fire[1] && ctl_r[1].pattern <= PAT_POS_EDGE
      && !fireRst |=> (state_r[1] == ST_IDLE)
      ##1 (trigOut_r[1] == !idleLevel(ctl_r[1].pattern) || ctl_r[1].negEdge))
    else $error("edge fire did not finish");
  soft_reset_a: assert property (fireRst |=> state_r[$past(trigIdx_r)] == ST_IDLE)
    else $error("fire unit soft reset ignored");
  // both ends of the pulse checked; the down-counter pins down the cycles between
  pulse_len_a: assert property (fire[2] && ctl_r[2].pattern > PAT_POS_EDGE
      && ctl_r[2].pattern != PAT_RESERVED && !fireRst
      |=> (state_r[2] == ST_PULSE && pulseCnt_r[2] == pulseLoad)
      ##9 (state_r[2] == ST_PULSE && pulseCnt_r[2] == 8'h01)
      ##1 (state_r[2] == ST_IDLE))
    else $error("pulse width wrong");
  reach_a: assert property (state_r[0] == ST_ARMED && hit[0] && !wrCtrl |=> state_r[0] != ST_ARMED)
    else $error("reached target not fired");

  fire_c: cover property (fire[0]);
  chain_c: cover property (chainArm[1] && arm[1]);
  pulse_c: cover property (pulseEnd[2]);
  fault_c: cover property (arm[0] && late[0]);
  loop_c: cover property (chainArm[0] && arm[0]);

endmodule

`default_nettype wire

/* File: testbench/trig_receiver.sv */
// receiver model of the equipment on the trigger pins
`timescale 1ns/1ps
`default_nettype none
module trig_receiver
  import ptp_trig_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_TRIG-1:0] trigOut,
  output logic [7:0] lowLen [NUM_TRIG]
);
  logic [7:0] run_r [NUM_TRIG]; // cycles low so far, per pin
  // width of each low pulse, latched when the pin rises again
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_TRIG; i++) begin
      if (rst) begin
        run_r[i] <= 8'h00;
        lowLen[i] <= 8'h00;
      end else if (trigOut[i] == 1'b0) begin
        run_r[i] <= run_r[i] + 8'h01;
      end else begin
        // a pin that was never low keeps its last width
        if (run_r[i] != 8'h00) begin
          lowLen[i] <= run_r[i];
        end
        run_r[i] <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/ptp_trigger_output_unit_tb_top.sv */
// self-checking bench for the ptp trigger output unit
`timescale 1ns/1ps
`default_nettype none
module ptp_trigger_output_unit_tb_top import ptp_trig_pkg::*;;
  logic clk, rst, regWr, regRd; // clock, reset, strobes
  logic [11:0] regAddr;
  logic [31:0] regWrData, regRdData, sysSec; // sysSec: bench-driven time
  logic [NS_W-1:0] sysNs;
  logic [NUM_TRIG-1:0] trigOut, fireCompleteFlag, fireFaultFlag;
  logic [NUM_CAP-1:0] capEnable;
  logic [7:0] lowLen [NUM_TRIG]; // pulse widths seen by the receiver
  int nErrors = 0;
  int checked = 0;
  int n0, n1, n;
  ptp_trigger_output_unit dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData), .sysSec(sysSec),
    .sysNs(sysNs), .trigOut(trigOut), .fireCompleteFlag(fireCompleteFlag),
    .fireFaultFlag(fireFaultFlag), .capEnable(capEnable));
  trig_receiver rx (.clk(clk), .rst(rst), .trigOut(trigOut), .lowLen(lowLen));
  // free-running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic testDone();
    $display("checks %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one write, strobe held for exactly one edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge clk);
    regWr = 1'b0;
  endtask
  // read data lands one edge after the strobe
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk);
    regRd = 1'b0;
    chk(regRdData, exp);
  endtask
  // bounded wait for a pin level; running out ends the run
  task automatic waitPin(input int u, input logic v, output int k);
    k = 0;
    while (trigOut[u] !== v) begin
      @(negedge clk);
      k++;
      if (k > 40) begin
        chk(32'(trigOut[u]), 32'(v));
        testDone();
      end
    end
  endtask
  // soft reset a unit, then load targets and control one
  task automatic setup(input logic [1:0] u, input logic [29:0] ns, input ctl_t c);
    wr(OFF_INDEX, {30'h0, u});
    wr(OFF_CTRL, 32'h0000_0004);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_TGT_SEC, 32'h0000_0000);
    wr(OFF_TGT_NS, {2'b00, ns});
    wr(OFF_CTL1, {c.chain, c.tail, 2'b00, c.upSel, c.now, c.notify, c.negEdge, c.pattern,
      20'h0_0000});
  endtask
  task automatic tReset();
    rdChk(OFF_TGT_NS, RST_WORD);
    rdChk(OFF_TGT_SEC, RST_WORD);
    rdChk(OFF_CTL1, RST_WORD);
    rdChk(12'h0550, RST_WORD);
    chk(32'(trigOut), 32'h0000_000F);
    $display("reset values done");
  endtask
  task automatic tTargets();
    wr(OFF_INDEX, 32'h0000_0001);
    wr(OFF_TGT_NS, 32'hFFFF_FFFF);
    wr(OFF_TGT_SEC, 32'hA5A5_5A5A);
    rdChk(OFF_TGT_NS, 32'h3FFF_FFFF);
    rdChk(OFF_TGT_SEC, 32'hA5A5_5A5A);
    wr(OFF_INDEX, 32'h0000_0002);
    rdChk(OFF_TGT_NS, RST_WORD);
    rdChk(OFF_TGT_SEC, RST_WORD);
    $display("target registers done");
  endtask
  // target of 100 ns met exactly; returns cycles from time match to pin
  task automatic tFire(input logic e, output int k);
    sysNs = '0;
    setup(2'h0, 30'h64, ctl_t'{1'b0, 1'b0, 2'h0, 1'b0, 1'b1, e, PAT_NEG_EDGE});
    chk(32'(trigOut[0]), 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0008);
    rdChk(OFF_CTRL, 32'h0000_0018);
    repeat (4) @(negedge clk);
    chk(32'(trigOut[0]), 32'h0000_0001);
    sysNs = 30'h64;
    waitPin(0, 1'b0, k);
    rdChk(OFF_CTRL, 32'h0000_0000);
    chk(32'(fireCompleteFlag[0]), 32'h0000_0001);
    $display("fire on time done");
  endtask
  // late target: refused without trigger-now, fired at once with it
  task automatic tLate();
    sysNs = 30'hC8;
    setup(2'h0, 30'h64, ctl_t'{1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0, PAT_NEG_EDGE});
    wr(OFF_CTRL, 32'h0000_0008);
    repeat (3) @(negedge clk);
    chk(32'({fireFaultFlag[0], trigOut[0]}), 32'h0000_0003);
    setup(2'h0, 30'h64, ctl_t'{1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, PAT_NEG_EDGE});
    wr(OFF_CTRL, 32'h0000_0008);
    waitPin(0, 1'b0, n);
    chk(32'({fireCompleteFlag[0], fireFaultFlag[0]}), 32'h0000_0000);
    $display("late target done");
  endtask
  // negative pulse width, and the reserved code refused
  task automatic tPulse();
    setup(2'h2, 30'h64, ctl_t'{1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0, 3'h2});
    wr(OFF_CTRL, 32'h0000_0008);
    waitPin(2, 1'b0, n);
    waitPin(2, 1'b1, n);
    @(negedge clk);
    chk(32'(lowLen[2]), 32'(PULSE_CYC));
    setup(2'h3, 30'h64, ctl_t'{1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0, PAT_RESERVED});
    wr(OFF_CTRL, 32'h0000_0008);
    repeat (PULSE_CYC + 4) @(negedge clk);
    chk(32'({trigOut[3], fireFaultFlag[3]}), 32'h0000_0003);
    $display("pulse patterns done");
  endtask
  // head unit 0 then tail unit 1, only the head enabled
  task automatic tCascade();
    sysSec = 32'h0000_0001;
    setup(2'h1, 30'h0, ctl_t'{1'b1, 1'b1, 2'h0, 1'b1, 1'b1, 1'b0, PAT_NEG_EDGE});
    setup(2'h0, 30'h0, ctl_t'{1'b1, 1'b0, 2'h1, 1'b1, 1'b1, 1'b0, PAT_NEG_EDGE});
    repeat (4) @(negedge clk);
    chk(32'(trigOut[1:0]), 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_0008);
    waitPin(0, 1'b0, n);
    waitPin(1, 1'b0, n);
    repeat (4) @(negedge clk);
    chk(32'(fireCompleteFlag[1:0]), 32'h0000_0003);
    rdChk(OFF_CTRL, 32'h0000_0000);
    rdChk(OFF_STATUS, 32'h0000_0087);
    wr(OFF_STATUS, 32'h0000_0081);
    rdChk(OFF_STATUS, 32'h0000_0006);
    $display("cascade done");
  endtask
  // two-unit chain with no tail loops until the head is soft reset
  task automatic tLoop();
    setup(2'h1, 30'h0, ctl_t'{1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, PAT_POS_PULSE});
    setup(2'h0, 30'h0, ctl_t'{1'b1, 1'b0, 2'h1, 1'b1, 1'b0, 1'b0, 3'h2});
    wr(OFF_CTRL, 32'h0000_0008);
    waitPin(0, 1'b0, n);
    waitPin(0, 1'b1, n);
    waitPin(1, 1'b1, n);
    waitPin(0, 1'b0, n);
    wr(OFF_CTRL, 32'h0000_0004);
    repeat (40) @(negedge clk);
    chk(32'(trigOut[1:0]), 32'h0000_0001);
    chk(32'(fireCompleteFlag[1:0]), 32'h0000_0000);
    rdChk(OFF_CTRL, RST_WORD);
    $display("chain loop done");
  endtask
  task automatic tCapture();
    wr(OFF_INDEX, 32'h0000_0100);
    wr(OFF_CTRL, 32'h0000_0002);
    chk(32'(capEnable), 32'h0000_0002);
    wr(OFF_INDEX, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_INDEX, 32'h0000_0100);
    wr(OFF_CTRL, 32'h0000_0003);
    chk(32'(capEnable), 32'h0000_0001);
    $display("capture reset done");
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = '0;
    sysSec = '0;
    sysNs = '0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    tReset();
    tTargets();
    tFire(1'b0, n0);
    tFire(1'b1, n1);
    chk(32'(n1), 32'(n0 + 1));
    tLate();
    tPulse();
    tCascade();
    tLoop();
    tCapture();
    testDone();
  end
endmodule
`default_nettype wire
